//--- rtl/lpc_regs.sv
// LIN PHY control and status register bank, top level.
// Assumes a simple one-cycle register port and an analog transceiver beside it.
//
// Chosen here: the plain strobed port.
`include "lpc_defines.svh"

module lpc_regs
	import lpc_pkg::*;
#(
	parameter int SLEW_SYNC_CYC = `LPC_SLEW_SYNC_CYC
) (
	input  wire logic       clk_i,          // 100 MHz system clock
	input  wire logic       rst_b_i,        // Async reset, active low
	input  wire logic [2:0] addr_i,         // Register offset
	input  wire logic [7:0] wdata_i,        // Write data
	input  wire logic       wr_i,           // Write strobe
	input  wire logic       rd_i,           // Read strobe
	output logic [7:0]      rdata_o,        // Read data, cycle after rd_i
	input  wire logic       special_mode_i, // Chip in special (test) mode
	input  wire logic       rx_data_i,      // Receiver output, asynchronous
	input  wire logic       overcurrent_i,  // Over-current sensor, asynchronous
	input  wire logic       route_reg_i,    // Routing selects register control
	output lpc_phy_ctl_s    phy_ctl_o,      // Controls to the transceiver
	output logic [7:0]      test_a_o,       // Factory test bits A
	output logic [7:0]      test_b_o,       // Factory test bits B
	output logic            irq_o           // Interrupt request, level
);
	lpc_req_s req;
	assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

	logic       rx_sync;
	logic       oc_sync;
	logic       tx_drive_r;
	logic [3:0] control_r;
	logic       oc_status_r;
	logic       oc_ie_r;
	logic       oc_flag_r;
	logic [1:0] slew_value;
	lpc_slew_e  slew_applied;
	logic       slew_locked;

	lpc_sync u_rx_sync (
		.clk_i   (clk_i),
		.rst_b_i (rst_b_i),
		.d_i     (rx_data_i),
		.q_o     (rx_sync)
	);

	lpc_sync u_oc_sync (
		.clk_i   (clk_i),
		.rst_b_i (rst_b_i),
		.d_i     (overcurrent_i),
		.q_o     (oc_sync)
	);

	// Address decode
	wire wr_data_w  = req.wr && (req.addr == `LPC_OFF_PORT_DATA);
	wire wr_ctl_w   = req.wr && (req.addr == `LPC_OFF_CONTROL);
	wire wr_ta_w    = req.wr && (req.addr == `LPC_OFF_TEST_A) && special_mode_i;
	wire wr_slew_w  = req.wr && (req.addr == `LPC_OFF_SLEW);
	wire wr_tb_w    = req.wr && (req.addr == `LPC_OFF_TEST_B) && special_mode_i;
	wire wr_ie_w    = req.wr && (req.addr == `LPC_OFF_IRQ_EN);
	wire wr_flag_w  = req.wr && (req.addr == `LPC_OFF_IRQ_FLAGS);

	// Over-current edge in either direction
	wire oc_change_w = oc_sync ^ oc_status_r;
	wire oc_clear_w  = wr_flag_w && req.wdata[`LPC_BIT_OC_FLAG];

	// Receive-only forced and locked while over-current stands
	wire rxo_nxt_w = oc_sync ? 1'b1 : req.wdata[`LPC_BIT_RX_ONLY];

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			tx_drive_r <= `LPC_RST_TX_DRIVE;
		end else if (wr_data_w) begin
			tx_drive_r <= req.wdata[`LPC_BIT_TX_DRIVE];
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			control_r <= `LPC_RST_CONTROL;
		end else if (wr_ctl_w) begin
			control_r <= {req.wdata[`LPC_BIT_ENABLE], rxo_nxt_w,
				req.wdata[`LPC_BIT_WAKEUP], req.wdata[`LPC_BIT_PULLUP]};
		end else if (oc_sync) begin
			control_r[`LPC_BIT_RX_ONLY] <= 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			test_a_o <= `LPC_RST_TEST;
			test_b_o <= `LPC_RST_TEST;
		end else begin
			if (wr_ta_w) test_a_o <= req.wdata;
			if (wr_tb_w) test_b_o <= req.wdata;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			oc_status_r <= 1'b0;
			oc_ie_r     <= 1'b0;
			oc_flag_r   <= 1'b0;
		end else begin
			oc_status_r <= oc_sync;
			if (wr_ie_w) oc_ie_r <= req.wdata[`LPC_BIT_OC_IE];
			// Set wins over a simultaneous clear
			if (oc_change_w) oc_flag_r <= 1'b1;
			else if (oc_clear_w) oc_flag_r <= 1'b0;
		end
	end

	lpc_slew_sync #(
		.SYNC_CYC (SLEW_SYNC_CYC)
	) u_slew (
		.clk_i    (clk_i),
		.rst_b_i  (rst_b_i),
		.wr_i     (wr_slew_w),
		.wdata_i  (req.wdata[1:0]),
		.value_o  (slew_value),
		.slew_o   (slew_applied),
		.locked_o (slew_locked)
	);

	// Transceiver controls
	wire enable_w  = control_r[`LPC_BIT_ENABLE];
	wire tx_ok_w   = enable_w && !control_r[`LPC_BIT_RX_ONLY] && !oc_sync;
	assign phy_ctl_o.phy_enable           = enable_w;
	assign phy_ctl_o.tx_enable            = tx_ok_w;
	assign phy_ctl_o.rx_enable            = enable_w;
	assign phy_ctl_o.wakeup_enable        = enable_w && control_r[`LPC_BIT_WAKEUP];
	assign phy_ctl_o.strong_pullup_select = enable_w && control_r[`LPC_BIT_PULLUP];
	// Recessive (high) whenever the transmitter is off, so lost data never reaches the bus
	assign phy_ctl_o.transmit_data_input  = (tx_ok_w && route_reg_i) ? tx_drive_r : 1'b1;
	assign phy_ctl_o.slew                 = slew_applied;

	// Read mux, unimplemented bits zero
	logic [7:0] rmux_w;
	always_comb begin
		rmux_w = 8'h00;
		case (req.addr)
			`LPC_OFF_PORT_DATA: rmux_w = {6'h00, tx_drive_r, rx_sync};
			`LPC_OFF_CONTROL:   rmux_w = {4'h0, control_r};
			`LPC_OFF_TEST_A:    rmux_w = test_a_o;
			`LPC_OFF_SLEW:      rmux_w = {slew_locked, 5'h00, slew_value};
			`LPC_OFF_TEST_B:    rmux_w = test_b_o;
			`LPC_OFF_STATUS:    rmux_w = {7'h00, oc_status_r};
			`LPC_OFF_IRQ_EN:    rmux_w = {oc_ie_r, 7'h00};
			`LPC_OFF_IRQ_FLAGS: rmux_w = {7'h00, oc_flag_r};
			default:            rmux_w = 8'h00;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rdata_o <= 8'h00;
		end else if (req.rd) begin
			rdata_o <= rmux_w;
		end else begin
			rdata_o <= 8'h00;
		end
	end

	assign irq_o = oc_ie_r && oc_flag_r;
endmodule : lpc_regs

//--- rtl/lpc_defines.svh
// Register offsets, field positions and reset values of the LIN PHY register bank.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef LPC_DEFINES_SVH
`define LPC_DEFINES_SVH

`define LPC_ADDR_W         3
`define LPC_OFF_PORT_DATA  3'h0
`define LPC_OFF_CONTROL    3'h1
`define LPC_OFF_TEST_A     3'h2
`define LPC_OFF_SLEW       3'h3
`define LPC_OFF_TEST_B     3'h4
`define LPC_OFF_STATUS     3'h5
`define LPC_OFF_IRQ_EN     3'h6
`define LPC_OFF_IRQ_FLAGS  3'h7

`define LPC_BIT_TX_DRIVE   1
`define LPC_BIT_RX_SENSE   0
`define LPC_BIT_ENABLE     3
`define LPC_BIT_RX_ONLY    2
`define LPC_BIT_WAKEUP     1
`define LPC_BIT_PULLUP     0
`define LPC_BIT_SLEW_LOCK  7
`define LPC_BIT_OC_STATUS  0
`define LPC_BIT_OC_IE      7
`define LPC_BIT_OC_FLAG    0

`define LPC_SLEW_NORMAL    2'h0
`define LPC_SLEW_SLOW      2'h1
`define LPC_SLEW_FAST      2'h2
`define LPC_SLEW_RSVD      2'h3

`define LPC_RST_TX_DRIVE   1'h1
`define LPC_RST_CONTROL    4'h0
`define LPC_RST_SLEW       2'h0
`define LPC_RST_TEST       8'h00
`define LPC_SLEW_SYNC_CYC  4

`endif

//--- rtl/lpc_pkg.sv
// Types shared by the LIN PHY register bank modules.
// Assumes lpc_defines.svh is on the include path.
`include "lpc_defines.svh"

package lpc_pkg;

	typedef enum logic [1:0] {
		LPC_SLEW_NORM,
		LPC_SLEW_SLW,
		LPC_SLEW_FST,
		LPC_SLEW_RES
	} lpc_slew_e;

	// Register port request
	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} lpc_req_s;

	// Controls going out to the analog transceiver
	typedef struct packed {
		logic      phy_enable;
		logic      tx_enable;
		logic      rx_enable;
		logic      wakeup_enable;
		logic      strong_pullup_select;
		logic      transmit_data_input;
		lpc_slew_e slew;
	} lpc_phy_ctl_s;

endpackage : lpc_pkg

//--- rtl/lpc_sync.sv
// Two-flop synchroniser for a level from the analog side.
// Assumes the input is asynchronous to clk_i.
module lpc_sync (
	input  wire logic clk_i,   // System clock
	input  wire logic rst_b_i, // Async reset, active low
	input  wire logic d_i,     // Asynchronous level
	output logic      q_o      // Synchronised level
);
	logic meta_r;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			meta_r <= 1'b0;
			q_o    <= 1'b0;
		end else begin
			meta_r <= d_i;
			q_o    <= meta_r;
		end
	end
endmodule : lpc_sync

//--- rtl/lpc_slew_sync.sv
// Slew setting hand-over to the slope control, with a write lock while it settles.
// Assumes the slope control takes a new setting within SYNC_CYC clocks.
`include "lpc_defines.svh"

module lpc_slew_sync
	import lpc_pkg::*;
#(
	parameter int SYNC_CYC = `LPC_SLEW_SYNC_CYC
) (
	input  wire logic       clk_i,    // System clock
	input  wire logic       rst_b_i,  // Async reset, active low
	input  wire logic       wr_i,     // Write to slew register
	input  wire logic [1:0] wdata_i,  // New slew code
	output logic [1:0]      value_o,  // Stored slew code
	output lpc_slew_e       slew_o,   // Setting seen by slope control
	output logic            locked_o  // Writes ignored while high
);
	localparam int CW = $clog2(SYNC_CYC + 1);

	logic [CW-1:0] cnt_r;
	logic [1:0]    applied_r;

	// Refused at elaboration: a zero count would never release the lock
	if (SYNC_CYC < 1) begin : g_bad_sync
		$error("SYNC_CYC must be at least 1");
	end

	wire accept_w = wr_i && !locked_o;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			value_o   <= `LPC_RST_SLEW;
			applied_r <= `LPC_RST_SLEW;
			cnt_r     <= '0;
			locked_o  <= 1'b0;
		end else if (accept_w) begin
			value_o  <= wdata_i;
			cnt_r    <= CW'(SYNC_CYC);
			locked_o <= 1'b1;
		end else if (locked_o) begin
			cnt_r <= cnt_r - CW'(1);
			if (cnt_r == CW'(1)) begin
				applied_r <= value_o;
				locked_o  <= 1'b0;
			end
		end
	end

	assign slew_o = lpc_slew_e'(applied_r);
endmodule : lpc_slew_sync

//--- bench/lpc_regs_properties.sv
// Port checker for the LIN PHY register bank.
// Bound to lpc_regs below; sees only its ports.
module lpc_regs_properties
	import lpc_pkg::*;
#(
	parameter int SLEW_SYNC_CYC = 4
) (
	input wire logic         clk_i,         // Clock
	input wire logic         rst_b_i,       // Reset, low
	input wire logic [2:0]   addr_i,        // Offset
	input wire logic [7:0]   wdata_i,       // Write data
	input wire logic         wr_i,          // Write
	input wire logic         rd_i,          // Read
	input wire logic [7:0]   rdata_o,       // Read data
	input wire logic         overcurrent_i, // Sensor
	input wire logic         route_reg_i,   // Routing
	input wire lpc_phy_ctl_s phy_ctl_o,     // Controls
	input wire logic         irq_o          // Interrupt
);
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (!rst_b_i);

	chk_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
		else $error("read data outside read cycle");
	chk_unimpl_zero: assert property (rd_i && addr_i inside {3'h0, 3'h1, 3'h5, 3'h7}
		|=> rdata_o[7:4] == 4'h0) else $error("unimplemented bits set");
	chk_shutdown_weak: assert property (!phy_ctl_o.phy_enable
		|-> !phy_ctl_o.strong_pullup_select && !phy_ctl_o.tx_enable) else $error("shutdown");
	chk_oc_tx_off: assert property (overcurrent_i[*3] |-> !phy_ctl_o.tx_enable)
		else $error("transmitter on in over-current");
	chk_txd_follow: assert property (wr_i && addr_i == 3'h0 ##1 route_reg_i
		&& phy_ctl_o.tx_enable |-> phy_ctl_o.transmit_data_input == $past(wdata_i[1]))
		else $error("transmit data not from port data");
	chk_slew_lock: assert property (wr_i && addr_i == 3'h3 ##2 rd_i && addr_i == 3'h3
		|=> rdata_o[7]) else $error("slew lock not shown");
	chk_oc_receive_only_select: assert property (overcurrent_i[*4] ##1 rd_i && addr_i == 3'h1
		|=> rdata_o[2]) else $error("receive-only not forced");
	chk_oc_status: assert property (overcurrent_i[*4] ##1 rd_i && addr_i == 3'h5
		|=> rdata_o == 8'h01) else $error("over-current status");
	chk_irq_off: assert property (wr_i && addr_i == 3'h6 && !wdata_i[7] |=> !irq_o)
		else $error("interrupt with enable clear");

	cover property ($rose(irq_o));
	cover property (wr_i && addr_i == 3'h3);
	cover property ($rose(overcurrent_i));
endmodule : lpc_regs_properties

bind lpc_regs lpc_regs_properties #(.SLEW_SYNC_CYC(SLEW_SYNC_CYC)) lpc_regs_properties_i (
	.clk_i, .rst_b_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .overcurrent_i,
	.route_reg_i, .phy_ctl_o, .irq_o);

//--- bench/lpc_lin_bus_model.sv
// LIN wire with one peer node, seen through the transceiver.
// Assumes the bench commands the peer level and bus shorts.
module lpc_lin_bus_model
	import lpc_pkg::*;
(
	input  wire logic         clk_i,      // Clock
	input  wire lpc_phy_ctl_s ctl_i,      // Bank controls
	input  wire logic         peer_dom_i, // Peer pulls low
	input  wire logic         oc_cmd_i,   // Short requested
	output logic              rx_o,       // Receiver output
	output logic              oc_o        // Sensor
);
	wire ours_dom = ctl_i.tx_enable && !ctl_i.transmit_data_input;

	// Pull-up keeps the wire recessive unless a node pulls it low
	always_ff @(posedge clk_i) begin
		rx_o <= !(ours_dom || peer_dom_i);
		oc_o <= oc_cmd_i;
	end
endmodule : lpc_lin_bus_model

//--- bench/tb_lpc_regs.sv
// Self-checking bench for lpc_regs against a register model.
// Assumes the checker binds itself and the bus model stands beside.
module tb_lpc_regs;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int SYNC = 8;
	logic	clk_i = 1'b0, rst_b_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
	logic	special_mode_i = 1'b0, route_reg_i = 1'b0, peer = 1'b0, oc_cmd = 1'b0;
	logic	rx, ovc, irq_o;
	logic [2:0]	addr_i = 3'h0;
	logic [7:0]	wdata_i = 8'h00, rdata_o, ta_o, tb_o;
	logic [31:0]	seed = 32'hF397;
	lpc_pkg::lpc_phy_ctl_s	ctl;
	int	err_total, total_checks, cr, sl, lk, ta, tb, oc, ie, fl, tx = 1;

	initial begin
		forever #5 clk_i = ~clk_i;
	end
	lpc_regs #(.SLEW_SYNC_CYC(SYNC)) lpc_regs_i (.clk_i, .rst_b_i, .addr_i, .wdata_i, .wr_i,
		.rd_i, .rdata_o, .special_mode_i, .rx_data_i(rx), .overcurrent_i(ovc), .route_reg_i,
		.phy_ctl_o(ctl), .test_a_o(ta_o), .test_b_o(tb_o), .irq_o);
	lpc_lin_bus_model lpc_lin_bus_model_i (.clk_i, .ctl_i(ctl), .peer_dom_i(peer),
		.oc_cmd_i(oc_cmd), .rx_o(rx), .oc_o(ovc));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	function automatic logic [7:0] expect_rd(input int a);
		int rx_e;
		rx_e = !peer && !(cr[3] && !cr[2] && !oc && route_reg_i && !tx);
		case (a)
			0: return 8'(tx * 2 + rx_e);
			1: return 8'(cr);
			2: return 8'(ta);
			3: return 8'(lk * 128 + sl);
			4: return 8'(tb);
			5: return 8'(oc);
			6: return 8'(ie * 128);
			default: return 8'(fl);
		endcase
	endfunction : expect_rd
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			err_total++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic bus(input logic w, input int a, input logic [7:0] d);
		@(posedge clk_i);
		wr_i <= w;
		rd_i <= !w;
		addr_i <= 3'(a);
		wdata_i <= d;
		@(posedge clk_i);
		wr_i <= 1'b0;
		rd_i <= 1'b0;
		#1;
		if (!w)
			chk("read data", expect_rd(a), rdata_o);
		else if (a == 0)
			tx = d[1];
		else if (a == 1)
			cr = (d & 15) | (oc * 4);
		else if (a == 3 && !lk) begin
			sl = d[1:0];
			lk = 1;
		end else if (a == 2 && special_mode_i)
			ta = d;
		else if (a == 4 && special_mode_i)
			tb = d;
		else if (a == 6)
			ie = d[7];
		else if (a == 7)
			fl = fl & !d[0];
		chk("irq", 8'(ie & fl), 8'(irq_o));
		chk("test a", 8'(ta), ta_o);
		chk("test b", 8'(tb), tb_o);
	endtask : bus
	task automatic end_sim();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : end_sim

	initial begin
		repeat (20000) @(posedge clk_i);
		err_total++;
		end_sim();
	end
	initial begin
		repeat (4) @(posedge clk_i);
		rst_b_i <= 1'b1;
		// Receiver level needs two edges through its synchroniser
		repeat (2) @(posedge clk_i);
		for (int a = 0; a < 8; a++) bus(0, a, 8'h00);
		for (int i = 0; i < 48; i++) begin
			@(posedge clk_i);
			seed = lfsr(seed);
			special_mode_i <= seed[8];
			route_reg_i <= seed[9];
			peer <= seed[10] & seed[11];
			if (seed[2:0] != 3'h3) begin
				bus(1, seed[2:0], seed[23:16]);
				repeat (4) @(posedge clk_i);
				bus(0, seed[2:0], 8'h00);
			end
		end
		for (int c = 0; c < 3; c++) begin
			bus(1, 3, 8'(c) | 8'hFC);
			bus(1, 3, 8'(3 - c));
			bus(0, 3, 8'h00);
			chk("slew held", 8'(c ? c - 1 : 0), 8'(ctl.slew));
			repeat (SYNC + 4) @(posedge clk_i);
			lk = 0;
			chk("slew", 8'(c), 8'(ctl.slew));
		end
		route_reg_i <= 1'b1;
		peer <= 1'b0;
		bus(1, 1, 8'h0B);
		chk("wake-up", 8'h01, 8'(ctl.wakeup_enable));
		chk("pull-up", 8'h01, 8'(ctl.strong_pullup_select));
		chk("tx enable", 8'h01, 8'(ctl.tx_enable));
		bus(1, 0, 8'h00);
		chk("tx data", 8'h00, 8'(ctl.transmit_data_input));
		repeat (4) @(posedge clk_i);
		bus(0, 0, 8'h00);
		oc_cmd <= 1'b1;
		repeat (8) @(posedge clk_i);
		oc = 1;
		fl = 1;
		cr = cr | 4;
		bus(1, 1, 8'h0B);
		chk("tx enable", 8'h00, 8'(ctl.tx_enable));
		bus(0, 1, 8'h00);
		bus(0, 5, 8'h00);
		bus(0, 0, 8'h00);
		bus(1, 6, 8'h80);
		bus(1, 6, 8'h00);
		bus(1, 6, 8'h80);
		bus(1, 7, 8'h00);
		bus(1, 7, 8'h01);
		oc_cmd <= 1'b0;
		repeat (8) @(posedge clk_i);
		oc = 0;
		fl = 1;
		bus(0, 7, 8'h00);
		bus(1, 1, 8'h08);
		bus(0, 1, 8'h00);
		bus(1, 1, 8'h03);
		chk("pull-up", 8'h00, 8'(ctl.strong_pullup_select));
		chk("phy enable", 8'h00, 8'(ctl.phy_enable));
		bus(0, 1, 8'h00);
		end_sim();
	end
endmodule : tb_lpc_regs
